// *** fpm_pkg.sv ***
package fpm_pkg;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [7:0] FPM_ADDR_CTRL   = 8'h00;
	localparam logic [7:0] FPM_ADDR_STATUS = 8'h04;
	localparam logic [7:0] FPM_ADDR_MASK   = 8'h08;
	localparam logic [7:0] FPM_ADDR_STATE  = 8'h0C;
	localparam logic [7:0] FPM_ADDR_PARAM  = 8'h10;

	// control fields
	localparam int FPM_CTRL_MODE_LSB = 0;
	localparam int FPM_CTRL_ACT_LSB  = 3;
	localparam int FPM_CTRL_QUAD_BIT = 5;
	localparam int FPM_CTRL_EN_BIT   = 6;
	localparam int FPM_CTRL_RST_BIT  = 7;
	localparam logic [6:0] FPM_CTRL_RESET = 7'h00;

	// status / mask bit positions
	localparam int FPM_ST_A_PF   = 0;
	localparam int FPM_ST_B_PF   = 1;
	localparam int FPM_ST_A_WF   = 2;
	localparam int FPM_ST_B_WF   = 3;
	localparam int FPM_ST_RESTART = 4;
	localparam int FPM_ST_SELBAD = 5;
	localparam int FPM_ST_W      = 6;
	localparam logic [5:0] FPM_ST_RESET = 6'h00;

	// per-bank parameter store
	localparam int FPM_PARAM_IDX_LSB = 16;
	localparam logic [3:0] FPM_PARAM_B_BASE = 4'hA;
	localparam logic [15:0] FPM_PARAM_RESET = 16'h0000;

	// fixed changeover moment, settle time of a new selection
	localparam int FPM_CHG_TIME_NS = 40;
	localparam int FPM_CLK_NS      = 10;
	localparam logic [7:0] FPM_CHG_CYCLES =
		8'((FPM_CHG_TIME_NS + FPM_CLK_NS - 1) / FPM_CLK_NS);

	// ------------------------------------------------------------
	// function modes and field pair activation
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		FPM_MODE_ONE       = 3'h0,
		FPM_MODE_ONE_100   = 3'h1,
		FPM_MODE_ONE_MULTI = 3'h2,
		FPM_MODE_TWO       = 3'h3,
		FPM_MODE_FOUR      = 3'h4,
		FPM_MODE_TWO_MULTI = 3'h5
	} fpm_mode_t;

	typedef enum logic [1:0] {
		FPM_ACT_FIXED   = 2'h0,
		FPM_ACT_OVERLAP = 2'h1,
		FPM_ACT_CHANGE  = 2'h2
	} fpm_act_t;

	typedef enum logic [1:0] {
		FPM_SEL_HOLD = 2'b00,
		FPM_SEL_WAIT = 2'b01
	} fpm_sel_state_t;

	// number of selectable field pairs per bank
	function automatic logic [6:0] fpm_pair_limit(input logic [2:0] m,
		input logic [1:0] a);
		case (m)
			FPM_MODE_ONE, FPM_MODE_TWO: begin
				if (a == FPM_ACT_FIXED)
					return 7'h01;
				else if (a == FPM_ACT_OVERLAP)
					return 7'h05;
				else
					return 7'h0A;
			end
			FPM_MODE_ONE_100:
				return 7'h64;
			FPM_MODE_ONE_MULTI, FPM_MODE_TWO_MULTI:
				return (a == FPM_ACT_FIXED) ? 7'h01 : 7'h0A;
			FPM_MODE_FOUR:
				return 7'h32;
			default:
				return 7'h00;
		endcase
	endfunction

	// number of configuration banks per function
	function automatic logic [3:0] fpm_bank_limit(input logic [2:0] m,
		input logic [1:0] a);
		case (m)
			FPM_MODE_ONE_MULTI:
				return (a == FPM_ACT_FIXED) ? 4'h1 : 4'hA;
			FPM_MODE_TWO_MULTI:
				return (a == FPM_ACT_FIXED) ? 4'h1 : 4'h5;
			FPM_MODE_ONE, FPM_MODE_ONE_100, FPM_MODE_TWO, FPM_MODE_FOUR:
				return 4'h1;
			default:
				return 4'h0;
		endcase
	endfunction

endpackage

// *** fpm_clear.sv ***
`timescale 1ns/100ps
module fpm_clear
	import fpm_pkg::*;
(
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic viol,
	input  wire logic blocked,
	output logic      field_free
);

	logic next_field_free;

	// ------------------------------------------------------------
	// free only while field unviolated and nothing blocks
	// ------------------------------------------------------------
	always_comb begin
		next_field_free = ~viol & ~blocked;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			field_free <= 1'b0;
		else
			field_free <= next_field_free;
	end

endmodule // fpm_clear

// *** fpm_sel.sv ***
`timescale 1ns/100ps
module fpm_sel
	import fpm_pkg::*;
(
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic [3:0] req_bank,
	input  wire logic [6:0] req_pair,
	input  wire logic [3:0] bank_lim,
	input  wire logic [6:0] pair_lim,
	input  wire logic       fixed,
	input  wire logic       immediate,
	output logic [3:0]      act_bank,
	output logic [6:0]      act_pair,
	output logic            sel_bad,
	output logic            bank_chg
);

	fpm_sel_state_t state, next_state;
	logic [7:0] cnt, next_cnt;
	logic [3:0] pend_bank, next_pend_bank, next_act_bank, tgt_bank;
	logic [6:0] pend_pair, next_pend_pair, next_act_pair, tgt_pair;
	logic       next_sel_bad, next_bank_chg, tgt_ok, load;

	// ------------------------------------------------------------
	// changeover: at once when overlapped or fixed, else after settle time
	// ------------------------------------------------------------
	always_comb begin
		tgt_bank = fixed ? 4'h0 : req_bank;
		tgt_pair = fixed ? 7'h00 : req_pair;
		tgt_ok = (tgt_pair < pair_lim) && (tgt_bank < bank_lim);
		next_state = state;
		next_cnt = cnt;
		next_pend_bank = pend_bank;
		next_pend_pair = pend_pair;
		next_act_bank = act_bank;
		next_act_pair = act_pair;
		load = 1'b0;
		case (state)
			FPM_SEL_HOLD: begin
				if (tgt_ok && {tgt_bank, tgt_pair} != {act_bank, act_pair}) begin
					if (immediate || fixed) begin
						load = 1'b1;
						next_act_bank = tgt_bank;
						next_act_pair = tgt_pair;
					end else begin
						next_state = FPM_SEL_WAIT;
						next_cnt = 8'h00;
						next_pend_bank = tgt_bank;
						next_pend_pair = tgt_pair;
					end
				end
			end
			FPM_SEL_WAIT: begin
				if (!tgt_ok || {tgt_bank, tgt_pair} == {act_bank, act_pair})
					next_state = FPM_SEL_HOLD;
				else if ({tgt_bank, tgt_pair} != {pend_bank, pend_pair}) begin
					next_cnt = 8'h00;
					next_pend_bank = tgt_bank;
					next_pend_pair = tgt_pair;
				end else if (cnt >= FPM_CHG_CYCLES - 8'h01) begin
					load = 1'b1;
					next_act_bank = pend_bank;
					next_act_pair = pend_pair;
					next_state = FPM_SEL_HOLD;
				end else
					next_cnt = cnt + 8'h01;
			end
			default:
				next_state = FPM_SEL_HOLD;
		endcase
		next_sel_bad = ~tgt_ok;
		next_bank_chg = load && (next_act_bank != act_bank);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state     <= FPM_SEL_HOLD;
			cnt       <= 8'h00;
			pend_bank <= 4'h0;
			pend_pair <= 7'h00;
			act_bank  <= 4'h0;
			act_pair  <= 7'h00;
			sel_bad   <= 1'b0;
			bank_chg  <= 1'b0;
		end else begin
			state     <= next_state;
			cnt       <= next_cnt;
			pend_bank <= next_pend_bank;
			pend_pair <= next_pend_pair;
			act_bank  <= next_act_bank;
			act_pair  <= next_act_pair;
			sel_bad   <= next_sel_bad;
			bank_chg  <= next_bank_chg;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_overlap_take: assert property (@(posedge pclk) disable iff (!presetn)
		(state == FPM_SEL_HOLD && immediate && !fixed && tgt_ok
			&& {tgt_bank, tgt_pair} != {act_bank, act_pair})
		|=> {act_bank, act_pair} == $past({tgt_bank, tgt_pair}))
		else $error("overlapped selection not taken at once");

	a_changeover_hold: assert property (@(posedge pclk) disable iff (!presetn)
		(state == FPM_SEL_HOLD && !immediate && !fixed && tgt_ok
			&& {tgt_bank, tgt_pair} != {act_bank, act_pair})
		|=> $stable({act_bank, act_pair}))
		else $error("changeover taken before settle time");

endmodule // fpm_sel

// *** fpm_mode_selector.sv ***
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
module fpm_mode_selector
	import fpm_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [3:0]  sel_a_bank,
	input  wire logic [6:0]  sel_a_pair,
	input  wire logic [3:0]  sel_b_bank,
	input  wire logic [6:0]  sel_b_pair,
	input  wire logic        pf_a_viol,
	input  wire logic        wf_a_viol,
	input  wire logic        pf_b_viol,
	input  wire logic        wf_b_viol,
	input  wire logic        internal_fault,
	output logic             func_a_protective_field_free,
	output logic             func_a_warning_field_free,
	output logic             func_b_protective_field_free,
	output logic             func_b_warning_field_free,
	output logic [3:0]       act_a_bank,
	output logic [6:0]       act_a_pair,
	output logic [3:0]       act_b_bank,
	output logic [6:0]       act_b_pair,
	output logic [15:0]      param_a,
	output logic [15:0]      param_b,
	output logic             irq
);

	logic [6:0]  ctrl, next_ctrl;
	logic [5:0]  status, next_status, mask, next_mask, events;
	logic        restart_pend, next_restart_pend;
	logic [31:0] next_prdata;
	logic        next_pready, next_pslverr, next_irq;
	logic [15:0] bank_param [0:15];
	logic        acc, done, addr_ok, wr, restart_wr, rd_status;
	logic [2:0]  mode;
	logic [1:0]  act;
	logic        fixed_sel, immediate, two_func, coupled, quad, enable;
	logic [3:0]  bank_lim, sa_bank, sb_bank, next_a_bank, next_b_bank;
	logic [6:0]  pair_lim, sa_pair, sb_pair, next_a_pair, next_b_pair;
	logic [3:0]  b_req_bank;
	logic [6:0]  b_req_pair;
	logic        a_bad, b_bad, a_bank_chg, block_a, block_b;
	logic        pf_a_hit, pf_b_hit;

	// ------------------------------------------------------------
	// apb decode, one wait state per transfer
	// ------------------------------------------------------------
	always_comb begin
		acc = psel & penable;
		done = acc & pready;
		addr_ok = (paddr == FPM_ADDR_CTRL) || (paddr == FPM_ADDR_STATUS)
			|| (paddr == FPM_ADDR_MASK) || (paddr == FPM_ADDR_STATE)
			|| (paddr == FPM_ADDR_PARAM);
		wr = done & pwrite & addr_ok;
		restart_wr = wr && paddr == FPM_ADDR_CTRL && pwdata[FPM_CTRL_RST_BIT];
		rd_status = done && !pwrite && paddr == FPM_ADDR_STATUS;
		next_pready = acc & ~pready;
		next_pslverr = acc & ~pready & ~addr_ok;
		next_prdata = 32'h0000_0000;
		if (acc && !pready && !pwrite) begin
			case (paddr)
				FPM_ADDR_CTRL:   next_prdata = {25'h0, ctrl};
				FPM_ADDR_STATUS: next_prdata = {26'h0, status};
				FPM_ADDR_MASK:   next_prdata = {26'h0, mask};
				FPM_ADDR_STATE:  next_prdata = {7'h0, act_b_bank, act_b_pair,
					act_a_bank, act_a_pair, restart_pend, a_bad, b_bad};
				FPM_ADDR_PARAM:  next_prdata = {16'h0, param_a};
				default:         next_prdata = 32'h0000_0000;
			endcase
		end
	end

	// ------------------------------------------------------------
	// mode decode and field pair ranges
	// ------------------------------------------------------------
	always_comb begin
		mode = ctrl[FPM_CTRL_MODE_LSB +: 3];
		act = ctrl[FPM_CTRL_ACT_LSB +: 2];
		quad = ctrl[FPM_CTRL_QUAD_BIT];
		enable = ctrl[FPM_CTRL_EN_BIT];
		pair_lim = fpm_pair_limit(mode, act);
		bank_lim = fpm_bank_limit(mode, act);
		fixed_sel = (act == FPM_ACT_FIXED)
			&& mode != FPM_MODE_ONE_100 && mode != FPM_MODE_FOUR;
		immediate = (act == FPM_ACT_OVERLAP)
			&& (mode == FPM_MODE_ONE || mode == FPM_MODE_TWO);
		two_func = (mode == FPM_MODE_TWO) || (mode == FPM_MODE_FOUR)
			|| (mode == FPM_MODE_TWO_MULTI);
		coupled = (mode != FPM_MODE_TWO);
		b_req_bank = coupled ? sel_a_bank : sel_b_bank;
		b_req_pair = coupled ? sel_a_pair : sel_b_pair;
	end

	// one selector per function, each with its own changeover
	fpm_sel u_sel_a (
		.pclk      (pclk),
		.presetn   (presetn),
		.req_bank  (sel_a_bank),
		.req_pair  (sel_a_pair),
		.bank_lim  (bank_lim),
		.pair_lim  (pair_lim),
		.fixed     (fixed_sel),
		.immediate (immediate),
		.act_bank  (sa_bank),
		.act_pair  (sa_pair),
		.sel_bad   (a_bad),
		.bank_chg  (a_bank_chg)
	);

	fpm_sel u_sel_b (
		.pclk      (pclk),
		.presetn   (presetn),
		.req_bank  (b_req_bank),
		.req_pair  (b_req_pair),
		.bank_lim  (bank_lim),
		.pair_lim  (pair_lim),
		.fixed     (fixed_sel),
		.immediate (immediate),
		.act_bank  (sb_bank),
		.act_pair  (sb_pair),
		.sel_bad   (b_bad),
		.bank_chg  ()
	);

	// ------------------------------------------------------------
	// switch-off conditions and protective field mapping
	// ------------------------------------------------------------
	always_comb begin
		block_a = internal_fault | ~enable | restart_pend | a_bad;
		block_b = block_a | ~two_func | b_bad;
		pf_a_hit = pf_a_viol | (quad & mode == FPM_MODE_FOUR & wf_a_viol);
		pf_b_hit = pf_b_viol | (quad & mode == FPM_MODE_FOUR & wf_b_viol);
		next_a_bank = sa_bank;
		next_a_pair = sa_pair;
		next_b_bank = coupled ? sa_bank : sb_bank;
		next_b_pair = coupled ? sa_pair : sb_pair;
	end

	fpm_clear u_clr_a_pf (
		.pclk       (pclk),
		.presetn    (presetn),
		.viol       (pf_a_hit),
		.blocked    (block_a),
		.field_free (func_a_protective_field_free)
	);

	fpm_clear u_clr_b_pf (
		.pclk       (pclk),
		.presetn    (presetn),
		.viol       (pf_b_hit),
		.blocked    (block_b),
		.field_free (func_b_protective_field_free)
	);

	fpm_clear u_clr_a_wf (
		.pclk       (pclk),
		.presetn    (presetn),
		.viol       (wf_a_viol),
		.blocked    (block_a),
		.field_free (func_a_warning_field_free)
	);

	fpm_clear u_clr_b_wf (
		.pclk       (pclk),
		.presetn    (presetn),
		.viol       (wf_b_viol),
		.blocked    (block_b),
		.field_free (func_b_warning_field_free)
	);

	// ------------------------------------------------------------
	// control, restart latch, sticky status and interrupt
	// ------------------------------------------------------------
	always_comb begin
		next_ctrl = ctrl;
		next_mask = mask;
		if (wr && paddr == FPM_ADDR_CTRL)
			next_ctrl = pwdata[6:0];
		if (wr && paddr == FPM_ADDR_MASK)
			next_mask = pwdata[5:0];
		// set wins over the restart clear
		next_restart_pend = (restart_pend & ~restart_wr)
			| (a_bank_chg & mode == FPM_MODE_ONE_MULTI);
		events = 6'h00;
		events[FPM_ST_A_PF] = pf_a_hit;
		events[FPM_ST_B_PF] = pf_b_hit & two_func;
		events[FPM_ST_A_WF] = wf_a_viol;
		events[FPM_ST_B_WF] = wf_b_viol & two_func;
		events[FPM_ST_RESTART] = restart_pend;
		events[FPM_ST_SELBAD] = a_bad | (b_bad & two_func);
		next_status = (rd_status ? FPM_ST_RESET : status) | events;
		next_irq = |(next_status & next_mask);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl         <= FPM_CTRL_RESET;
			mask         <= FPM_ST_RESET;
			status       <= FPM_ST_RESET;
			restart_pend <= 1'b0;
			irq          <= 1'b0;
			prdata       <= 32'h0000_0000;
			pready       <= 1'b0;
			pslverr      <= 1'b0;
			act_a_bank   <= 4'h0;
			act_a_pair   <= 7'h00;
			act_b_bank   <= 4'h0;
			act_b_pair   <= 7'h00;
		end else begin
			ctrl         <= next_ctrl;
			mask         <= next_mask;
			status       <= next_status;
			restart_pend <= next_restart_pend;
			irq          <= next_irq;
			prdata       <= next_prdata;
			pready       <= next_pready;
			pslverr      <= next_pslverr;
			act_a_bank   <= next_a_bank;
			act_a_pair   <= next_a_pair;
			act_b_bank   <= next_b_bank;
			act_b_pair   <= next_b_pair;
		end
	end

	// ------------------------------------------------------------
	// per-bank safety parameters, A in 0..9, B from 10 up
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 16; i++)
				bank_param[i] <= FPM_PARAM_RESET;
			param_a <= FPM_PARAM_RESET;
			param_b <= FPM_PARAM_RESET;
		end else begin
			if (wr && paddr == FPM_ADDR_PARAM)
				bank_param[pwdata[FPM_PARAM_IDX_LSB +: 4]] <= pwdata[15:0];
			param_a <= bank_param[sa_bank];
			param_b <= bank_param[4'(FPM_PARAM_B_BASE + sb_bank)];
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_pf_a_breach: assert property (@(posedge pclk) disable iff (!presetn)
		pf_a_viol |=> !func_a_protective_field_free)
		else $error("function A protective breach not reported");

	a_pf_a_isolated: assert property (@(posedge pclk) disable iff (!presetn)
		(pf_a_viol && !pf_b_hit && !block_b) |=> func_b_protective_field_free)
		else $error("function A breach leaked onto function B");

	a_fault_off: assert property (@(posedge pclk) disable iff (!presetn)
		internal_fault |=> !func_a_protective_field_free
			&& !func_b_protective_field_free && !func_a_warning_field_free
			&& !func_b_warning_field_free)
		else $error("clear signal high during fault");

	a_quad_second: assert property (@(posedge pclk) disable iff (!presetn)
		(mode == FPM_MODE_FOUR && quad && wf_b_viol)
		|=> !func_b_protective_field_free)
		else $error("second protective field ignored");

	a_wf_b_breach: assert property (@(posedge pclk) disable iff (!presetn)
		wf_b_viol |=> !func_b_warning_field_free)
		else $error("function B warning breach not reported");

	a_coupled_index: assert property (@(posedge pclk) disable iff (!presetn)
		(mode == FPM_MODE_FOUR || mode == FPM_MODE_TWO_MULTI)
		|=> {act_b_bank, act_b_pair} == {act_a_bank, act_a_pair})
		else $error("function B index differs from function A");

	a_bank_restart: assert property (@(posedge pclk) disable iff (!presetn)
		(a_bank_chg && mode == FPM_MODE_ONE_MULTI)
		|=> restart_pend ##1 !func_a_protective_field_free)
		else $error("bank change released outputs without restart");

	a_single_func_b: assert property (@(posedge pclk) disable iff (!presetn)
		!two_func |=> !func_b_protective_field_free && !func_b_warning_field_free)
		else $error("function B active in one-function mode");

	a_pready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
		(acc && !pready) |=> pready ##1 !pready)
		else $error("apb answer not exactly one cycle");

endmodule // fpm_mode_selector

// *** fpm_ctrl_model.sv ***
`timescale 1ns/100ps
// ------------------------------------------------------------
// safety controller model: drives field pair requests
// ------------------------------------------------------------
module fpm_ctrl_model
	import fpm_pkg::*;
(
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic [3:0] cmd_a_bank,
	input  wire logic [6:0] cmd_a_pair,
	input  wire logic [3:0] cmd_b_bank,
	input  wire logic [6:0] cmd_b_pair,
	output logic [3:0]      sel_a_bank,
	output logic [6:0]      sel_a_pair,
	output logic [3:0]      sel_b_bank,
	output logic [6:0]      sel_b_pair
);
	// each function's request held steady between commands
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel_a_bank <= 4'h0;
			sel_a_pair <= 7'h00;
			sel_b_bank <= 4'h0;
			sel_b_pair <= 7'h00;
		end else begin
			sel_a_bank <= cmd_a_bank;
			sel_a_pair <= cmd_a_pair;
			sel_b_bank <= cmd_b_bank;
			sel_b_pair <= cmd_b_pair;
		end
	end
endmodule // fpm_ctrl_model

// *** fpm_mode_selector_tb.sv ***
`timescale 1ns/100ps
module fpm_mode_selector_tb
	import fpm_pkg::*;
;
	typedef struct packed {
		logic [7:0] ctrl;
		logic [3:0] ab;
		logic [6:0] ap;
		logic [3:0] bb;
		logic [6:0] bp;
		logic [3:0] v;
		logic [21:0] e;
		logic [3:0] ef;
	} fpm_row_t;

	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic        irq, er, pfa, wfa, pfb, wfb, fault;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0]  ca_b, cb_b, sa_b, sb_b, aab, abb, fr;
	logic [6:0]  ca_p, cb_p, sa_p, sb_p, aap, abp;
	logic [15:0] pa, pb;
	int          num_errors = 0;
	int          cmp_count = 0;
	int          cyc = 0;

	// ctrl, A req, B req, breaches, expected index, expected free
	fpm_row_t rows [10] = '{
		'{8'h40, 4'h0, 7'h03, 4'h0, 7'h00, 4'h0, 22'h0, 4'hC},
		'{8'h48, 4'h0, 7'h04, 4'h0, 7'h00, 4'h8,
			{4'h0, 7'h04, 4'h0, 7'h04}, 4'h4},
		'{8'h50, 4'h0, 7'h09, 4'h0, 7'h00, 4'h0,
			{4'h0, 7'h09, 4'h0, 7'h09}, 4'hC},
		'{8'h51, 4'h0, 7'h63, 4'h0, 7'h00, 4'h0,
			{4'h0, 7'h63, 4'h0, 7'h63}, 4'hC},
		'{8'h52, 4'h9, 7'h09, 4'h0, 7'h00, 4'h0,
			{4'h9, 7'h09, 4'h9, 7'h09}, 4'hC},
		'{8'h53, 4'h0, 7'h02, 4'h0, 7'h07, 4'h1,
			{4'h0, 7'h02, 4'h0, 7'h07}, 4'hE},
		'{8'h54, 4'h0, 7'h31, 4'h0, 7'h03, 4'h2,
			{4'h0, 7'h31, 4'h0, 7'h31}, 4'hD},
		'{8'h74, 4'h0, 7'h31, 4'h0, 7'h03, 4'h4,
			{4'h0, 7'h31, 4'h0, 7'h31}, 4'h3},
		'{8'h74, 4'h0, 7'h31, 4'h0, 7'h03, 4'h1,
			{4'h0, 7'h31, 4'h0, 7'h31}, 4'hC},
		'{8'h55, 4'h4, 7'h09, 4'h0, 7'h00, 4'h0,
			{4'h4, 7'h09, 4'h4, 7'h09}, 4'hF}
	};

	fpm_mode_selector fpm_mode_selector_inst (.pclk(pclk), .presetn(presetn),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sel_a_bank(sa_b), .sel_a_pair(sa_p),
		.sel_b_bank(sb_b), .sel_b_pair(sb_p), .pf_a_viol(pfa),
		.wf_a_viol(wfa), .pf_b_viol(pfb), .wf_b_viol(wfb),
		.internal_fault(fault), .func_a_protective_field_free(fr[3]),
		.func_a_warning_field_free(fr[2]),
		.func_b_protective_field_free(fr[1]),
		.func_b_warning_field_free(fr[0]), .act_a_bank(aab),
		.act_a_pair(aap), .act_b_bank(abb), .act_b_pair(abp),
		.param_a(pa), .param_b(pb), .irq(irq));

	fpm_ctrl_model fpm_ctrl_model_inst (.pclk(pclk), .presetn(presetn),
		.cmd_a_bank(ca_b), .cmd_a_pair(ca_p), .cmd_b_bank(cb_b),
		.cmd_b_pair(cb_p), .sel_a_bank(sa_b), .sel_a_pair(sa_p),
		.sel_b_bank(sb_b), .sel_b_pair(sb_p));

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task check(input string n, input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask

	task end_sim;
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task tick(input int k);
		repeat (k) @(posedge pclk);
	endtask

	// one apb transfer, held until pready is sampled high
	task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge pclk);
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		psel <= 1'b1;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// new request, then settle past the changeover time
	task pick(input logic [3:0] ab, input logic [6:0] ap,
		input logic [3:0] bb, input logic [6:0] bp);
		ca_b <= ab;
		ca_p <= ap;
		cb_b <= bb;
		cb_p <= bp;
		tick(14);
	endtask

	// clock and hang guard
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	always @(posedge pclk) begin
		cyc++;
		if (cyc == 6000) begin
			num_errors++;
			end_sim;
		end
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		{presetn, psel, penable, pwrite, pfa, wfa, pfb, wfb, fault} = 9'h0;
		{paddr, pwdata, ca_b, ca_p, cb_b, cb_p} = 62'h0;
		tick(8);
		presetn <= 1'b1;
		tick(2);
		check("free rst", fr, 4'h0);
		check("irq rst", irq, 1'b0);
		apb(FPM_ADDR_CTRL, 1'b0, 32'h0);
		check("ctrl rst", rd, 32'h0);
		apb(8'h20, 1'b0, 32'h0);
		check("unmapped err", er, 1'b1);
		check("unmapped data", rd, 32'h0);
		foreach (rows[i]) begin
			apb(FPM_ADDR_CTRL, 1'b1, {24'h0, rows[i].ctrl});
			{pfa, wfa, pfb, wfb} <= rows[i].v;
			pick(rows[i].ab, rows[i].ap, rows[i].bb, rows[i].bp);
			apb(FPM_ADDR_CTRL, 1'b1, {24'h0, rows[i].ctrl | 8'h80});
			tick(3);
			check("act", {aab, aap, abb, abp}, rows[i].e);
			check("free", fr, rows[i].ef);
		end
		{pfa, wfa, pfb, wfb} <= 4'h0;
		apb(FPM_ADDR_CTRL, 1'b1, 32'h52);
		pick(4'h2, 7'h00, 4'h0, 7'h00);
		check("restart hold", fr[3], 1'b0);
		apb(FPM_ADDR_STATE, 1'b0, 32'h0);
		check("restart flag", rd[2], 1'b1);
		apb(FPM_ADDR_CTRL, 1'b1, 32'hD2);
		tick(3);
		check("restart done", fr[3], 1'b1);
		apb(FPM_ADDR_PARAM, 1'b1, 32'h0002_A5C3);
		apb(FPM_ADDR_PARAM, 1'b1, 32'h000C_3C5A);
		tick(3);
		check("param a", pa, 16'hA5C3);
		check("param b", pb, 16'h3C5A);
		apb(FPM_ADDR_STATUS, 1'b0, 32'h0);
		apb(FPM_ADDR_MASK, 1'b1, 32'h20);
		apb(FPM_ADDR_CTRL, 1'b1, 32'h48);
		pick(4'h0, 7'h05, 4'h0, 7'h00);
		check("irq range", irq, 1'b1);
		check("free range", fr, 4'h0);
		apb(FPM_ADDR_STATUS, 1'b0, 32'h0);
		check("st range", rd[5], 1'b1);
		pick(4'h0, 7'h04, 4'h0, 7'h00);
		apb(FPM_ADDR_STATUS, 1'b0, 32'h0);
		apb(FPM_ADDR_MASK, 1'b1, 32'h0);
		pfa <= 1'b1;
		tick(3);
		pfa <= 1'b0;
		tick(2);
		check("irq masked", irq, 1'b0);
		apb(FPM_ADDR_MASK, 1'b1, 32'h1);
		tick(2);
		check("irq unmasked", irq, 1'b1);
		apb(FPM_ADDR_STATUS, 1'b0, 32'h0);
		check("st pf a", rd[0], 1'b1);
		tick(2);
		check("irq cleared", irq, 1'b0);
		apb(FPM_ADDR_CTRL, 1'b1, 32'h46);
		tick(14);
		check("bad mode", fr, 4'h0);
		apb(FPM_ADDR_CTRL, 1'b1, 32'h53);
		pick(4'h0, 7'h01, 4'h0, 7'h02);
		check("two free", fr, 4'hF);
		pfa <= 1'b1;
		tick(3);
		check("pf a only", fr, 4'h7);
		pfa <= 1'b0;
		fault <= 1'b1;
		tick(3);
		check("fault", fr, 4'h0);
		fault <= 1'b0;
		tick(3);
		check("fault gone", fr, 4'hF);
		// reset again in mid-run, outputs checked low two cycles later
		presetn <= 1'b0;
		tick(2);
		check("free mid rst", fr, 4'h0);
		check("act mid rst", {aab, aap, abb, abp}, 22'h0);
		check("irq mid rst", irq, 1'b0);
		presetn <= 1'b1;
		tick(2);
		apb(FPM_ADDR_CTRL, 1'b0, 32'h0);
		check("ctrl mid rst", rd, 32'h0);
		check("free after rst", fr, 4'h0);
		end_sim;
	end
endmodule // fpm_mode_selector_tb
